// [logic/hw_interrupt_sources_ctrl.sv]
// Hardware interrupt source controller: external pin plus keyscan pins,
// carrier transmitter end-of-cycle and core timer requests toward the CPU.
// Assumes all inputs synchronous to core_clk_i and a CPU that pulses
// ext_done_i when it finishes servicing the external interrupt.
//
// Functional notes
// - While the CPU global mask bit is set no hardware request reaches the CPU; clearing it lets them pass.
// - Each keyscan pin with its interrupt enabled joins the external pin as one external request.
// - In edge-only builds a falling edge on the pin or an enabled keyscan pin raises the request.
// - In edge-and-level builds a low level or falling edge on the pin or enabled keyscan pin raises it.
// - Edge-only versus edge-and-level is a build-time parameter, not a software setting.
// - While the external suppress bit is set the latch still sets and is forwarded once it clears.
// - The external latch clears at reset and when the CPU finishes the external service with no new set in that cycle.
// - The external request is latched right after the falling edge, then synchronised, and uses vector 3ffa.
// - The branch-on-level test sees the pin level combined with the keyscan interrupt signals.
// - End-of-cycle flag and its enable together raise the modulator request through vector 3ff8.
// - The modulator raises no new request while the chip is in wait mode.
// - A timer wrap from its maximum to zero with its enable set raises the timer request.
// - An elapsed real-time period with its enable set raises the timer request.
// - Both timer causes share the vector at 3ff6.
// - With several requests pending the one with the highest vector address is served first.
// - An external request arriving under the global mask stays latched until the mask clears; modulator and timer requests follow their flags.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.svh"

module hw_interrupt_sources_ctrl #(
    // Build-time trigger choice: 0 edge only, 1 edge and level; no register reaches it
    parameter bit LEVEL_SENSE = 1'b0
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Register bus
    input wire irq_ctrl_pkg::axi_req_s axi_i,
    output var irq_ctrl_pkg::axi_rsp_s axi_o,
    // External sources
    input wire logic ext_pin_n_i,
    input wire logic [7:0] keyscan_port_pins_i,
    // Carrier modulator
    input wire logic end_cycle_flag_i,
    input wire logic end_cycle_irq_en_i,
    input wire logic ext_int_suppress_i,
    input wire logic wait_mode_i,
    // Core timer
    input wire logic timer_wrap_flag_i,
    input wire logic timer_wrap_irq_en_i,
    input wire logic periodic_flag_i,
    input wire logic periodic_irq_en_i,
    // CPU side
    input wire logic cpu_int_mask_i,
    input wire logic ext_done_i,
    output logic ext_irq_o,
    output logic mod_irq_o,
    output logic tmr_irq_o,
    output logic cpu_irq_o,
    output logic [15:0] vector_o,
    output logic ext_level_o,
    output logic irq_o
);

    irq_ctrl_pkg::ctrl_state_s state_reg;
    irq_ctrl_pkg::ctrl_state_s state_next;
    logic [7:0] keys_low;
    logic [7:0] keys_fall;
    logic pin_fall;
    logic ext_set;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic [2:0] events;

    // Falling edge of an active-low input sampled last cycle
    function automatic logic fall_edge(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction

    // Highest vector address wins among pending requests
    function automatic logic [15:0] pick_vector(input logic e, input logic m, input logic t);
        if (e) begin
            return `VEC_EXT;
        end else if (m) begin
            return `VEC_MOD;
        end else if (t) begin
            return `VEC_TMR;
        end
        return `VEC_NONE;
    endfunction

    // Register read decode
    function automatic logic [31:0] read_word(input irq_ctrl_pkg::ctrl_state_s s, input logic lvl,
                                              input logic [7:0] addr);
        logic [31:0] w;
        w = `RST_WORD;
        unique case (addr)
            `OFF_KEY_EN: w[7:0] = s.key_en;
            `OFF_STATUS: w[`EV_W-1:0] = s.status;
            `OFF_MASK: w[`EV_W-1:0] = s.mask;
            `OFF_STATE: begin
                w[`ST_LATCH] = s.ext_latch;
                w[`ST_EXT] = s.ext_req;
                w[`ST_MOD] = s.mod_req;
                w[`ST_TMR] = s.tmr_req;
                w[`ST_LEVEL] = lvl;
                w[`ST_VEC_LO +: 16] = s.vector;
            end
            default: w = `RST_WORD;
        endcase
        return w;
    endfunction

    function automatic logic addr_ok(input logic [7:0] addr);
        return addr == `OFF_KEY_EN || addr == `OFF_STATUS || addr == `OFF_MASK || addr == `OFF_STATE;
    endfunction

    // Keyscan pins only count where software enabled them
    assign keys_low = ~keyscan_port_pins_i & state_reg.key_en;
    // A keyscan pin counts as falling only if it was high at the last enabled edge
    assign keys_fall = state_reg.keys_prev & ~keyscan_port_pins_i & state_reg.key_en;
    assign pin_fall = fall_edge(state_reg.pin_prev, ext_pin_n_i);

    // Edge terms always; level terms only in the level build
    assign ext_set = pin_fall | (|keys_fall)
                     | (LEVEL_SENSE & (~ext_pin_n_i | (|keys_low)));

    // Handshakes; nothing is taken while frozen
    assign aw_take = axi_i.awvalid & axi_o.awready;
    assign w_take = axi_i.wvalid & axi_o.wready;
    assign ar_take = axi_i.arvalid & axi_o.arready;
    assign do_write = clk_en_i & state_reg.aw_have & state_reg.w_have & ~state_reg.bvalid;

    // Bus outputs: readies combinational, data from flops
    always_comb begin
        axi_o.awready = clk_en_i & ~state_reg.aw_have & ~state_reg.bvalid;
        axi_o.wready = clk_en_i & ~state_reg.w_have & ~state_reg.bvalid;
        axi_o.bvalid = state_reg.bvalid;
        axi_o.bresp = state_reg.bresp;
        axi_o.arready = clk_en_i & ~state_reg.rvalid;
        axi_o.rvalid = state_reg.rvalid;
        axi_o.rdata = state_reg.rdata;
        axi_o.rresp = state_reg.rresp;
    end

    // CPU side: mask gating is immediate, requests are flop levels
    assign ext_irq_o = state_reg.ext_req & ~cpu_int_mask_i;
    assign mod_irq_o = state_reg.mod_req & ~cpu_int_mask_i;
    assign tmr_irq_o = state_reg.tmr_req & ~cpu_int_mask_i;
    assign cpu_irq_o = ext_irq_o | mod_irq_o | tmr_irq_o;
    // Vector follows pending requests even under the mask; only the request lines are gated
    assign vector_o = state_reg.vector;
    assign ext_level_o = ext_pin_n_i & ~(|keys_low);
    // Software view: sticky events gated by the enable mask register
    assign irq_o = |(state_reg.status & state_reg.mask);

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        events = `RST_EVENTS;
        if (clk_en_i) begin
            state_next.pin_prev = ext_pin_n_i;
            state_next.keys_prev = keyscan_port_pins_i;
            // Latch first, set beats the CPU's clear
            if (ext_set) begin
                state_next.ext_latch = 1'b1;
            end else if (ext_done_i) begin
                state_next.ext_latch = 1'b0;
            end
            // Sync stage, held back while suppressed; latch keeps it pending
            state_next.ext_req = state_reg.ext_latch & ~ext_int_suppress_i;
            // Wait mode may keep an old request but never starts one
            state_next.mod_req = end_cycle_flag_i & end_cycle_irq_en_i
                                 & (state_reg.mod_req | ~wait_mode_i);
            state_next.tmr_req = (timer_wrap_flag_i & timer_wrap_irq_en_i)
                                 | (periodic_flag_i & periodic_irq_en_i);
            state_next.vector = pick_vector(state_next.ext_req, state_next.mod_req, state_next.tmr_req);
            events[`EV_EXT] = state_next.ext_req & ~state_reg.ext_req;
            events[`EV_MOD] = state_next.mod_req & ~state_reg.mod_req;
            events[`EV_TMR] = state_next.tmr_req & ~state_reg.tmr_req;
            // Write address and data captured in either order
            if (aw_take) begin
                state_next.aw_have = 1'b1;
                state_next.aw_addr = axi_i.awaddr[`ADDR_MSB:0];
            end
            if (w_take) begin
                state_next.w_have = 1'b1;
                state_next.wdata = axi_i.wdata;
                state_next.wstrb = axi_i.wstrb;
            end
            if (do_write) begin
                state_next.bvalid = 1'b1;
                state_next.bresp = addr_ok(state_reg.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
                if (state_reg.wstrb[0]) begin
                    unique case (state_reg.aw_addr)
                        `OFF_KEY_EN: state_next.key_en = state_reg.wdata[7:0];
                        `OFF_STATUS: state_next.status = state_reg.status & ~state_reg.wdata[`EV_W-1:0];
                        `OFF_MASK: state_next.mask = state_reg.wdata[`EV_W-1:0];
                        default: state_next.mask = state_reg.mask;
                    endcase
                end
            end
            if (state_reg.bvalid & axi_i.bready) begin
                state_next.bvalid = 1'b0;
                state_next.aw_have = 1'b0;
                state_next.w_have = 1'b0;
            end
            // Event set wins over a same-cycle write-one clear
            state_next.status = state_next.status | events;
            if (ar_take) begin
                state_next.rvalid = 1'b1;
                state_next.rdata = read_word(state_reg, ext_level_o, axi_i.araddr[`ADDR_MSB:0]);
                state_next.rresp = addr_ok(axi_i.araddr[`ADDR_MSB:0]) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (state_reg.rvalid & axi_i.rready) begin
                state_next.rvalid = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
            state_reg.pin_prev <= 1'b1; // Idle pins are high, so release shows no false edge
            state_reg.keys_prev <= 8'hff;
            state_reg.key_en <= `RST_KEY_EN;
            state_reg.bresp <= `RESP_OKAY;
            state_reg.rresp <= `RESP_OKAY;
        end else begin
            state_reg <= state_next;
        end
    end

    // Checks share the core clock and sleep while reset is asserted
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    // The external path in two steps: a pin edge, then an unsuppressed latch
    sequence pin_falls_s;
        clk_en_i && state_reg.pin_prev && !ext_pin_n_i;
    endsequence

    sequence latch_unsuppressed_s;
        clk_en_i && state_reg.ext_latch && !ext_int_suppress_i;
    endsequence

    // Global mask gate is combinational, so no masked cycle can leak a request
    mask_blocks_cpu_a: assert property (
        cpu_int_mask_i |-> !cpu_irq_o)
        else $error("request passed under global mask");

    // Latch set paths; edge terms in every build, level terms only in the level build
    pin_edge_latch_a: assert property (
        pin_falls_s |=> state_reg.ext_latch)
        else $error("pin falling edge not latched");
    key_edge_latch_a: assert property (
        clk_en_i && (|keys_fall) |=> state_reg.ext_latch)
        else $error("keyscan edge not latched");
    level_latch_a: assert property (
        LEVEL_SENSE && clk_en_i && !ext_pin_n_i |=> state_reg.ext_latch)
        else $error("low level not latched");
    edge_only_a: assert property (
        !LEVEL_SENSE && clk_en_i && !state_reg.ext_latch && !pin_fall && !(|keys_fall)
        |=> !state_reg.ext_latch)
        else $error("latch set without edge in edge-only build");

    // Suppress holds only the forward stage; the end of service clears the latch
    suppress_hold_a: assert property (
        clk_en_i && state_reg.ext_latch && ext_int_suppress_i && !ext_done_i
        |=> state_reg.ext_latch && !state_reg.ext_req)
        else $error("suppressed latch lost or forwarded");
    done_clear_a: assert property (
        clk_en_i && ext_done_i && !ext_set |=> !state_reg.ext_latch)
        else $error("latch not cleared by service end");
    sync_stage_a: assert property (
        pin_falls_s ##1 latch_unsuppressed_s |=> state_reg.ext_req && state_reg.vector == `VEC_EXT)
        else $error("external request not forwarded one cycle after latch");
    branch_level_a: assert property (
        ext_level_o == (ext_pin_n_i && !(|(~keyscan_port_pins_i & state_reg.key_en))))
        else $error("branch level mismatch");

    // Peripheral requests; wait mode keeps an old modulator request but starts none
    mod_wait_a: assert property (
        clk_en_i && wait_mode_i && !state_reg.mod_req |=> !state_reg.mod_req)
        else $error("modulator request started in wait mode");
    mod_req_a: assert property (
        clk_en_i && end_cycle_flag_i && end_cycle_irq_en_i && !wait_mode_i |=> state_reg.mod_req)
        else $error("modulator request missing");
    tmr_req_a: assert property (
        clk_en_i && ((timer_wrap_flag_i && timer_wrap_irq_en_i) || (periodic_flag_i && periodic_irq_en_i))
        |=> state_reg.tmr_req)
        else $error("timer request missing");

    // Vector priority and release of a request held under the mask
    vector_prio_a: assert property (
        state_reg.mod_req && state_reg.tmr_req && !state_reg.ext_req |-> state_reg.vector == `VEC_MOD)
        else $error("priority vector wrong");
    held_mask_a: assert property (
        state_reg.ext_req && cpu_int_mask_i ##1 !cpu_int_mask_i && state_reg.ext_req |-> cpu_irq_o)
        else $error("held request not released");

endmodule

`default_nettype wire

// [logic/irq_ctrl_map.svh]
// Register offsets, field positions, reset values and vector addresses
// of the hardware interrupt source controller.
// Assumes inclusion by bare name from the controller module.
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

// Register byte offsets on the AXI4-Lite slave
`define OFF_KEY_EN 8'h00
`define OFF_STATUS 8'h04
`define OFF_MASK 8'h08
`define OFF_STATE 8'h0c
`define ADDR_LSB 2
`define ADDR_MSB 7

// Event bit positions in status and mask
`define EV_EXT 0
`define EV_MOD 1
`define EV_TMR 2
`define EV_W 3

// State register field positions
`define ST_LATCH 0
`define ST_EXT 1
`define ST_MOD 2
`define ST_TMR 3
`define ST_LEVEL 4
`define ST_VEC_LO 16

// Reset values
`define RST_KEY_EN 8'h00
`define RST_EVENTS 3'h0
`define RST_WORD 32'h0000_0000

// Service vector addresses, high byte of each pair first in priority
`define VEC_EXT 16'h3ffa
`define VEC_MOD 16'h3ff8
`define VEC_TMR 16'h3ff6
`define VEC_NONE 16'h0000

// AXI response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [logic/irq_ctrl_pkg.sv]
// Types of the hardware interrupt source controller.
// Assumes the map header supplies all numeric constants.
`default_nettype none
package irq_ctrl_pkg;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_s;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rsp_s;

    // Whole state of the controller
    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] key_en;
        logic [2:0] status;
        logic [2:0] mask;
        logic pin_prev;
        logic [7:0] keys_prev;
        logic ext_latch;
        logic ext_req;
        logic mod_req;
        logic tmr_req;
        logic [15:0] vector;
    } ctrl_state_s;

endpackage

`default_nettype wire

// [tb/cpu_core_model.sv]
// CPU core stand-in that services the external request and reports completion.
// Assumes the controller runs on the same clock and reset as this model.
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Service behaviour chosen by the bench
    input wire logic ack_en_i,
    input wire logic [3:0] delay_i,
    // Controller side
    input wire logic ext_irq_i,
    output logic ext_done_o
);
    logic [3:0] cnt_reg;
    logic armed_reg;

    // One completion pulse per request; rearm only after the line drops,
    // so a slow clear in the controller never earns a second pulse
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= 4'h0;
            armed_reg <= 1'b1;
            ext_done_o <= 1'b0;
        end else begin
            ext_done_o <= 1'b0;
            if (!ext_irq_i) begin
                cnt_reg <= 4'h0;
                armed_reg <= 1'b1;
            end else if (ack_en_i && armed_reg) begin
                if (cnt_reg == delay_i) begin
                    ext_done_o <= 1'b1;
                    armed_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the hardware interrupt source controller.
// Assumes a CPU stand-in that acknowledges requests; a level-build copy shares every input.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.svh"

module tb_top;
    logic core_clk, resetn, ack_en, ext_done, pin_n, eoc, eoc_en, sup, wt;
    logic wrap, wrap_en, per, per_en, cpu_mask;
    logic ext_irq, mod_irq, tmr_irq, cpu_irq, ext_level, irq, lvl_ext_irq, clk_en;
    logic [3:0] delay;
    logic [7:0] keys;
    logic [15:0] vector;
    logic [31:0] rd;
    irq_ctrl_pkg::axi_req_s ax;
    irq_ctrl_pkg::axi_rsp_s rs;
    int mismatches, total_checks, cycles;
    // Inputs {eoc, en, wait, wrap, wrap_en, per, per_en, mask}, then {mod, tmr}, then vector
    logic [25:0] rows [8] = '{{8'hc0, 2'b10, 16'h3ff8}, {8'h80, 2'b00, 16'h0000},
        {8'he0, 2'b00, 16'h0000}, {8'h18, 2'b01, 16'h3ff6}, {8'h06, 2'b01, 16'h3ff6},
        {8'h14, 2'b00, 16'h0000}, {8'hd9, 2'b00, 16'h3ff8}, {8'hd8, 2'b11, 16'h3ff8}};

    hw_interrupt_sources_ctrl #(.LEVEL_SENSE(1'b0)) i_dut (.core_clk_i(core_clk), .resetn_i(resetn),
        .clk_en_i(clk_en), .axi_i(ax), .axi_o(rs), .ext_pin_n_i(pin_n), .keyscan_port_pins_i(keys),
        .end_cycle_flag_i(eoc), .end_cycle_irq_en_i(eoc_en), .ext_int_suppress_i(sup), .wait_mode_i(wt),
        .timer_wrap_flag_i(wrap), .timer_wrap_irq_en_i(wrap_en), .periodic_flag_i(per),
        .periodic_irq_en_i(per_en), .cpu_int_mask_i(cpu_mask), .ext_done_i(ext_done), .ext_irq_o(ext_irq),
        .mod_irq_o(mod_irq), .tmr_irq_o(tmr_irq), .cpu_irq_o(cpu_irq), .vector_o(vector),
        .ext_level_o(ext_level), .irq_o(irq));

    // Level-build copy on the same inputs; only its external request is compared
    if (1) begin : lvl
        hw_interrupt_sources_ctrl #(.LEVEL_SENSE(1'b1)) i_dut (.core_clk_i(core_clk), .resetn_i(resetn),
            .clk_en_i(clk_en), .axi_i(ax), .axi_o(), .ext_pin_n_i(pin_n), .keyscan_port_pins_i(keys),
            .end_cycle_flag_i(eoc), .end_cycle_irq_en_i(eoc_en), .ext_int_suppress_i(sup), .wait_mode_i(wt),
            .timer_wrap_flag_i(wrap), .timer_wrap_irq_en_i(wrap_en), .periodic_flag_i(per),
            .periodic_irq_en_i(per_en), .cpu_int_mask_i(cpu_mask), .ext_done_i(ext_done),
            .ext_irq_o(lvl_ext_irq), .mod_irq_o(), .tmr_irq_o(), .cpu_irq_o(), .vector_o(), .ext_level_o(),
            .irq_o());
    end

    cpu_core_model i_cpu (.clk_i(core_clk), .resetn_i(resetn), .ack_en_i(ack_en), .delay_i(delay),
        .ext_irq_i(ext_irq), .ext_done_o(ext_done));

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Hang guard, well above the hundred-odd cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waits n edges, then lets that edge's updates land
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge core_clk);
        ax <= '{awaddr: {24'h0, a}, awvalid: 1'b1, wdata: d, wstrb: 4'hf, wvalid: 1'b1, bready: 1'b1, default: '0};
        forever begin
            @(posedge core_clk);
            if (aw && rs.awready) begin
                aw = 1'b0;
                ax.awvalid <= 1'b0;
            end
            if (w && rs.wready) begin
                w = 1'b0;
                ax.wvalid <= 1'b0;
            end
            if (rs.bvalid) begin
                chk("bresp", rs.bresp, `RESP_OKAY);
                ax.bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] resp, output logic [31:0] d);
        @(posedge core_clk);
        ax <= '{araddr: {24'h0, a}, arvalid: 1'b1, rready: 1'b1, default: '0};
        forever begin
            @(posedge core_clk);
            if (ax.arvalid && rs.arready) begin
                ax.arvalid <= 1'b0;
            end
            if (rs.rvalid) begin
                d = rs.rdata;
                chk("rresp", rs.rresp, resp);
                ax.rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        ax = '0;
        {clk_en, resetn, ack_en, delay, pin_n, keys} = {1'b1, 1'b0, 1'b1, 4'h0, 1'b1, 8'hff};
        {eoc, eoc_en, wt, wrap, wrap_en, per, per_en, cpu_mask, sup} = '0;
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        settle(1);
        chk("vector", vector, `VEC_NONE);
        chk("cpu_irq", cpu_irq, 1'b0);
        // Reset values and an unmapped place
        for (int i = 0; i < 3; i++) begin
            axi_rd(8'(4 * i), `RESP_OKAY, rd);
            chk("reg_reset", rd, `RST_WORD);
        end
        axi_rd(8'h10, `RESP_SLVERR, rd);
        chk("unmapped", rd, 32'h0000_0000);
        // Modulator and timer sources through the table
        foreach (rows[i]) begin
            @(posedge core_clk);
            {eoc, eoc_en, wt, wrap, wrap_en, per, per_en, cpu_mask} <= rows[i][25:18];
            settle(2);
            chk("mod_irq", mod_irq, rows[i][17]);
            chk("tmr_irq", tmr_irq, rows[i][16]);
            chk("vector", vector, rows[i][15:0]);
            chk("cpu_irq", cpu_irq, |rows[i][17:16]);
        end
        @(posedge core_clk);
        {eoc, eoc_en, wt, wrap, wrap_en, per, per_en, cpu_mask} <= 8'h00;
        // Sticky status, mask and clear
        axi_rd(`OFF_STATUS, `RESP_OKAY, rd);
        chk("status", rd, 32'h0000_0006);
        chk("irq_masked", irq, 1'b0);
        axi_wr(`OFF_MASK, 32'h0000_0007);
        settle(1);
        chk("irq_on", irq, 1'b1);
        axi_wr(`OFF_STATUS, 32'h0000_0007);
        settle(1);
        chk("irq_off", irq, 1'b0);
        axi_rd(`OFF_STATUS, `RESP_OKAY, rd);
        chk("status_clr", rd, 32'h0000_0000);
        // Pin edge with prompt service; pin held low retriggers only the level build
        @(posedge core_clk);
        pin_n <= 1'b0;
        settle(2);
        chk("ext_irq", ext_irq, 1'b1);
        chk("vector", vector, `VEC_EXT);
        settle(6);
        chk("ext_done_clr", ext_irq, 1'b0);
        chk("level_retrigger", lvl_ext_irq, 1'b1);
        // Suppressed request stays latched
        @(posedge core_clk);
        {ack_en, pin_n} <= 2'b01;
        @(posedge core_clk);
        {sup, pin_n} <= 2'b10;
        settle(4);
        chk("ext_suppressed", ext_irq, 1'b0);
        axi_rd(`OFF_STATE, `RESP_OKAY, rd);
        chk("latch_held", rd[1:0], 2'b01);
        @(posedge core_clk);
        sup <= 1'b0;
        settle(2);
        chk("ext_released", ext_irq, 1'b1);
        // Global mask blocks, then lets the held request through
        @(posedge core_clk);
        cpu_mask <= 1'b1;
        settle(2);
        chk("ext_masked", ext_irq, 1'b0);
        @(posedge core_clk);
        cpu_mask <= 1'b0;
        #1;
        chk("ext_unmasked", ext_irq, 1'b1);
        // Slow service clears the latch
        @(posedge core_clk);
        {pin_n, delay, ack_en} <= {1'b1, 4'h5, 1'b1};
        for (int n = 0; n < 20 && ext_irq !== 1'b0; n++) settle(1);
        chk("ext_serviced", ext_irq, 1'b0);
        axi_rd(`OFF_STATE, `RESP_OKAY, rd);
        chk("latch_clr", rd[0], 1'b0);
        // Keyscan pins join the external request only when enabled
        axi_wr(`OFF_KEY_EN, 32'h0000_0004);
        @(posedge core_clk);
        keys <= 8'hf7;
        settle(3);
        chk("key_disabled", ext_irq, 1'b0);
        chk("level_disabled", ext_level, 1'b1);
        @(posedge core_clk);
        keys <= 8'hf3;
        settle(2);
        chk("key_enabled", ext_irq, 1'b1);
        chk("level_enabled", ext_level, 1'b0);
        chk("vector", vector, `VEC_EXT);
        // Mid-run reset drops the pending latch, the request and the vector
        @(posedge core_clk);
        resetn <= 1'b0;
        settle(2);
        chk("rst_ext_irq", ext_irq, 1'b0);
        chk("rst_vector", vector, `VEC_NONE);
        @(posedge core_clk);
        {resetn, keys} <= {1'b1, 8'hff};
        axi_rd(`OFF_STATE, `RESP_OKAY, rd);
        chk("rst_state", rd, 32'h0000_0010);
        // A low clock enable holds every request and refuses the bus
        @(posedge core_clk);
        {clk_en, eoc, eoc_en} <= 3'b011;
        settle(3);
        chk("frozen_mod", mod_irq, 1'b0);
        chk("frozen_ready", rs.arready, 1'b0);
        @(posedge core_clk);
        clk_en <= 1'b1;
        settle(2);
        chk("thawed_mod", mod_irq, 1'b1);
        finish_test();
    end
endmodule

`default_nettype wire
